// >>> hw/ppfs_pkg.sv
// Package for the programming-port flash status block.
// Holds register layouts, command codes, flash geometry and timing.
package ppfs_pkg;
  // Command codes from the serial programming port
  localparam logic [7:0] CMD_WR_TEST = 8'hF0;
  localparam logic [7:0] CMD_RD_TEST = 8'hF1;
  localparam logic [7:0] CMD_WR_CTRL = 8'h02;
  localparam logic [7:0] CMD_RD_CTRL = 8'h03;
  localparam logic [7:0] CMD_RD_STAT = 8'h04;
  // Status register field positions
  localparam int STAT_FLASH_CONTROL_MODE_FLAG_BIT = 7;
  localparam int STAT_PROT1_BIT = 6;
  localparam int STAT_RWP_BIT = 5;
  localparam int STAT_BUSY_BIT = 3;
  // Control and test register field positions
  localparam int CTRL_MODE_BIT = 7;
  localparam int TEST_BYPASS_BIT = 2;
  // Reset values
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [7:0] TEST_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Option byte shadow field positions
  localparam int OPT_PROT1_BIT = 1;
  localparam int OPT_RWP_BIT = 0;
  // Flash geometry
  localparam int PAGE_BYTES = 512;
  localparam int ROW_BYTES = 64;
  localparam int ROWS_PER_PAGE = 8;
  localparam int PAGES_PER_SECTOR = 16;
  localparam int INFO_BYTES = 256;
  localparam int INFO_PAGES = 4;
  localparam logic [1:0] INFO_USER_PAGE = 2'h3;
  localparam int ADDR_W = 16;
  localparam int PAGE_SHIFT = 9;
  localparam int SECTOR_SHIFT = 13;
  localparam int INFO_PAGE_SHIFT = 6;
  localparam int ARRAY_DATA_W = 16;
  // Operation timing
  localparam int CLK_KHZ = 10000;
  localparam int PROG_TIME_US = 65;
  localparam int PROG_CYCLES = (PROG_TIME_US * CLK_KHZ) / 1000;
  localparam int ERASE_TIME_US = 400;
  localparam int ERASE_CYCLES = (ERASE_TIME_US * CLK_KHZ) / 1000;
  localparam int TMR_W = 16;

  typedef enum logic [1:0] {
    PPFS_OP_PROG = 2'b00,
    PPFS_OP_PAGE_ERASE = 2'b01,
    PPFS_OP_MASS_ERASE = 2'b10,
    PPFS_OP_READ = 2'b11
  } ppfs_op_t;

  typedef struct packed {
    logic valid;
    logic from_port;
    logic info;
    ppfs_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } ppfs_req_t;

  typedef struct packed {
    logic we;
    logic re;
    logic [7:0] code;
    logic [7:0] wdata;
  } ppfs_cmd_t;
endpackage

// >>> hw/ppfs_op_timer.sv
// Down-counter that holds a busy level for a loaded number of cycles.
// Assumes the caller loads only while idle.
`timescale 1ns/1ns
module ppfs_op_timer
  import ppfs_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic load_in,
  input wire logic [TMR_W-1:0] count_in,
  output logic busy_out,
  output logic done_out
);
  logic [TMR_W-1:0] cnt;
  logic [TMR_W-1:0] next_cnt;
  logic done;
  logic next_done;

  always_comb begin
    next_cnt = cnt;
    next_done = 1'b0;
    if (load_in) begin
      next_cnt = count_in;
    end else if (cnt != '0) begin
      next_cnt = cnt - 1'b1;
      next_done = (cnt == TMR_W'(1));
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= '0;
      done <= 1'b0;
    end else if (ce_in) begin
      cnt <= next_cnt;
      done <= next_done;
    end
  end

  assign busy_out = (cnt != '0);
  assign done_out = done;
endmodule

// >>> hw/ppfs_addr_check.sv
// Classifies a flash address: page, sector, info page and access rights.
// Pure combinational; assumes byte addresses.
`timescale 1ns/1ns
module ppfs_addr_check
  import ppfs_pkg::*;
(
  input wire ppfs_req_t req_in,
  input wire logic [7:0] sector_lock_in,
  output logic allowed_out,
  output logic [6:0] page_out
);
  logic [2:0] sector;
  logic [1:0] info_page;

  always_comb begin
    page_out = req_in.addr[ADDR_W-1:PAGE_SHIFT];
    sector = req_in.addr[ADDR_W-1:SECTOR_SHIFT];
    info_page = req_in.addr[7:INFO_PAGE_SHIFT];
    allowed_out = 1'b1;
    if (req_in.info) begin
      // Only the user page (info page 3) is reachable; no sector locks here
      allowed_out = (info_page == INFO_USER_PAGE);
    end else if (!req_in.from_port && req_in.op != PPFS_OP_READ) begin
      // CPU writes honour sector locks; 16 pages per sector
      allowed_out = !sector_lock_in[sector];
    end
    if (!req_in.from_port && req_in.op == PPFS_OP_MASS_ERASE) begin
      allowed_out = 1'b0;
    end
  end
endmodule

// >>> hw/ppfs_top.sv
// Programming-port status, test configuration and flash sequencing.
// Assumes port commands arrive already decoded, synchronous to mclk_in.
`timescale 1ns/1ns
module ppfs_top
  import ppfs_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic por_in,
  input wire logic brownout_in,
  input wire logic strap_in,
  input wire ppfs_cmd_t cmd_in,
  input wire logic [7:0] option_shadow_in,
  input wire logic [7:0] sector_lock_in,
  input wire ppfs_req_t cpu_req_in,
  input wire ppfs_req_t port_req_in,
  input wire logic [ARRAY_DATA_W-1:0] array_rdata_in,
  output logic [7:0] cmd_rdata_out,
  output logic cmd_rvalid_out,
  output logic port_mode_out,
  output logic bypass_out,
  output logic req_ready_out,
  output logic req_reject_out,
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  output logic array_we_out,
  output logic array_erase_out,
  output logic array_mass_out,
  output logic array_hi_out,
  output logic [ADDR_W-1:0] array_addr_out,
  output logic [ARRAY_DATA_W-1:0] array_wdata_out
);
  typedef enum logic [1:0] {
    PPFS_ST_IDLE = 2'b00,
    PPFS_ST_BUSY = 2'b01,
    PPFS_ST_READ = 2'b10
  } ppfs_state_t;

  // Mode registers
  logic port_mode;
  logic next_port_mode;
  logic flash_ctl;
  logic next_flash_ctl;
  logic [7:0] test_cfg;
  logic [7:0] next_test_cfg;
  logic strap_all_high;
  logic next_strap_all_high;
  logic por_seen;
  logic next_por_seen;

  // Sequencer registers
  ppfs_state_t state;
  ppfs_state_t next_state;
  logic port_busy;
  logic next_port_busy;
  ppfs_req_t cur;
  ppfs_req_t next_cur;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic rvalid;
  logic next_rvalid;
  logic reject;
  logic next_reject;
  logic [7:0] cmd_rdata;
  logic [7:0] next_cmd_rdata;
  logic cmd_rvalid;
  logic next_cmd_rvalid;

  ppfs_req_t sel;
  logic sel_ok;
  logic launch;
  logic tmr_load;
  logic [TMR_W-1:0] tmr_count;
  logic tmr_busy;
  logic tmr_done;
  logic [6:0] sel_page;
  logic [7:0] status;

  ppfs_addr_check u_check (
    .req_in(sel),
    .sector_lock_in(sector_lock_in),
    .allowed_out(sel_ok),
    .page_out(sel_page)
  );

  ppfs_op_timer u_timer (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .load_in(tmr_load),
    .count_in(tmr_count),
    .busy_out(tmr_busy),
    .done_out(tmr_done)
  );

  // Status is assembled from live state only
  always_comb begin
    status = STAT_RESET;
    status[STAT_FLASH_CONTROL_MODE_FLAG_BIT] = flash_ctl;
    status[STAT_PROT1_BIT] = option_shadow_in[OPT_PROT1_BIT];
    status[STAT_RWP_BIT] = option_shadow_in[OPT_RWP_BIT];
    // Reads never raise busy; only port program and erase do, not CPU ones
    status[STAT_BUSY_BIT] = port_busy |
      (launch & sel.from_port & (sel.op != PPFS_OP_READ));
  end

  // Mode and command handling
  always_comb begin
    next_port_mode = port_mode;
    next_flash_ctl = flash_ctl;
    next_test_cfg = test_cfg;
    next_strap_all_high = strap_all_high;
    next_por_seen = por_in;
    next_cmd_rdata = cmd_rdata;
    next_cmd_rvalid = 1'b0;
    if (por_in) begin
      next_strap_all_high = por_seen ? (strap_all_high & strap_in) : strap_in;
    end
    if (por_seen && !por_in && strap_all_high) begin
      next_port_mode = 1'b0;
      next_flash_ctl = 1'b0;
    end
    if (brownout_in) begin
      next_port_mode = 1'b0;
      next_flash_ctl = 1'b0;
      next_test_cfg = TEST_RESET;
    end else if (cmd_in.we) begin
      next_port_mode = 1'b1;
      if (cmd_in.code == CMD_WR_TEST) begin
        // Only the bypass bit is stored; reserved bits drop
        next_test_cfg = TEST_RESET;
        next_test_cfg[TEST_BYPASS_BIT] =
          cmd_in.wdata[TEST_BYPASS_BIT];
      end else if (cmd_in.code == CMD_WR_CTRL) begin
        next_flash_ctl = cmd_in.wdata[CTRL_MODE_BIT];
      end
      // Status writes have no target register; like any write they only set port mode
    end else if (cmd_in.re) begin
      next_cmd_rvalid = 1'b1;
      if (cmd_in.code == CMD_RD_TEST) begin
        next_cmd_rdata = test_cfg;
      end else if (cmd_in.code == CMD_RD_CTRL) begin
        next_cmd_rdata = CTRL_RESET;
        next_cmd_rdata[CTRL_MODE_BIT] = flash_ctl;
      end else if (cmd_in.code == CMD_RD_STAT) begin
        next_cmd_rdata = status;
      end else begin
        next_cmd_rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      port_mode <= 1'b0;
      flash_ctl <= 1'b0;
      test_cfg <= TEST_RESET;
      strap_all_high <= 1'b0;
      por_seen <= 1'b0;
      cmd_rdata <= 8'h00;
      cmd_rvalid <= 1'b0;
    end else if (ce_in) begin
      port_mode <= next_port_mode;
      flash_ctl <= next_flash_ctl;
      test_cfg <= next_test_cfg;
      strap_all_high <= next_strap_all_high;
      por_seen <= next_por_seen;
      cmd_rdata <= next_cmd_rdata;
      cmd_rvalid <= next_cmd_rvalid;
    end
  end

  // Request selection: port wins when in flash control mode
  always_comb begin
    sel = cpu_req_in;
    if (port_req_in.valid && port_mode && flash_ctl) begin
      sel = port_req_in;
      sel.from_port = 1'b1;
    end else begin
      sel.from_port = 1'b0;
    end
  end

  // Bypass mode hands the array to the pins, so the sequencer idles
  assign launch = (state == PPFS_ST_IDLE) && sel.valid && sel_ok &&
                  !test_cfg[TEST_BYPASS_BIT];

  always_comb begin
    next_state = state;
    next_port_busy = port_busy;
    next_cur = cur;
    next_rdata = rdata;
    next_rvalid = 1'b0;
    next_reject = 1'b0;
    tmr_load = 1'b0;
    tmr_count = '0;
    if (state == PPFS_ST_IDLE && sel.valid && !sel_ok) begin
      next_reject = 1'b1;
    end
    case (state)
      PPFS_ST_IDLE: begin
        if (launch) begin
          next_cur = sel;
          if (sel.op == PPFS_OP_READ) begin
            next_state = PPFS_ST_READ;
          end else begin
            next_state = PPFS_ST_BUSY;
            next_port_busy = sel.from_port;
            tmr_load = 1'b1;
            // Erase works on whole pages only
            tmr_count = (sel.op == PPFS_OP_PROG) ?
              TMR_W'(PROG_CYCLES) : TMR_W'(ERASE_CYCLES);
          end
        end
      end
      PPFS_ST_BUSY: begin
        if (tmr_done || (!tmr_busy && !tmr_load)) begin
          next_state = PPFS_ST_IDLE;
          next_port_busy = 1'b0;
        end
      end
      PPFS_ST_READ: begin
        // Byte pick from the 16-bit word
        next_rdata = cur.addr[0] ? array_rdata_in[15:8] :
                                   array_rdata_in[7:0];
        next_rvalid = 1'b1;
        next_state = PPFS_ST_IDLE;
      end
      default: begin
        next_state = PPFS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= PPFS_ST_IDLE;
      port_busy <= 1'b0;
      cur <= '0;
      rdata <= 8'h00;
      rvalid <= 1'b0;
      reject <= 1'b0;
    end else if (ce_in) begin
      state <= next_state;
      port_busy <= next_port_busy;
      cur <= next_cur;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
      reject <= next_reject;
    end
  end

  // Array drive; page and info rows map to 512 and 64-byte units
  always_comb begin
    array_addr_out = (state == PPFS_ST_IDLE) ? sel.addr : cur.addr;
    if (state != PPFS_ST_IDLE && cur.op == PPFS_OP_PAGE_ERASE) begin
      array_addr_out = cur.info ?
        {cur.addr[ADDR_W-1:INFO_PAGE_SHIFT], 6'h00} :
        {cur.addr[ADDR_W-1:PAGE_SHIFT], 9'h000};
    end
    array_wdata_out = {cur.data, cur.data};
    array_hi_out = cur.addr[0];
  end

  assign array_we_out = (state == PPFS_ST_BUSY) && (cur.op == PPFS_OP_PROG);
  assign array_erase_out = (state == PPFS_ST_BUSY) &&
                           (cur.op == PPFS_OP_PAGE_ERASE);
  assign array_mass_out = (state == PPFS_ST_BUSY) &&
                          (cur.op == PPFS_OP_MASS_ERASE);
  assign req_ready_out = (state == PPFS_ST_IDLE) &&
                         !test_cfg[TEST_BYPASS_BIT];
  assign req_reject_out = reject;
  assign rdata_out = rdata;
  assign rvalid_out = rvalid;
  assign cmd_rdata_out = cmd_rdata;
  assign cmd_rvalid_out = cmd_rvalid;
  assign port_mode_out = port_mode;
  assign bypass_out = test_cfg[TEST_BYPASS_BIT];
endmodule

// >>> sim/ppfs_top_chk.sv
// Port checker for ppfs_top, bound at the foot of this file.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ns
module ppfs_top_chk
  import ppfs_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic por_in,
  input wire logic brownout_in,
  input wire logic strap_in,
  input wire ppfs_cmd_t cmd_in,
  input wire logic [7:0] option_shadow_in,
  input wire logic [7:0] cmd_rdata_out,
  input wire logic cmd_rvalid_out,
  input wire logic port_mode_out,
  input wire logic bypass_out,
  input wire logic req_ready_out,
  input wire logic array_we_out,
  input wire logic array_erase_out,
  input wire logic array_mass_out
);
  logic strap_ok;
  logic next_strap_ok;
  logic rd_stat;
  assign rd_stat = ce_in && cmd_in.re && !cmd_in.we && !brownout_in
                   && cmd_in.code == CMD_RD_STAT;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  // Strap seen high on every cycle of the current power-on period
  always_comb begin
    next_strap_ok = strap_ok;
    if (!por_in) begin
      next_strap_ok = 1'b1;
    end else if (!strap_in) begin
      next_strap_ok = 1'b0;
    end
  end
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strap_ok <= 1'b1;
    end else begin
      strap_ok <= next_strap_ok;
    end
  end

  test_write_a: assert property (
    ce_in && cmd_in.we && cmd_in.code == CMD_WR_TEST && !brownout_in
    && !por_in |=> bypass_out == $past(cmd_in.wdata[TEST_BYPASS_BIT]))
    else $error("bypass differs from written bit");
  test_read_a: assert property (
    ce_in && cmd_in.re && !cmd_in.we && !brownout_in
    && cmd_in.code == CMD_RD_TEST |=> cmd_rvalid_out
    && cmd_rdata_out == {5'h00, $past(bypass_out), 2'h0})
    else $error("test read value wrong");
  stat_resv_a: assert property (
    rd_stat |=> cmd_rvalid_out && cmd_rdata_out[4] == 1'b0
    && cmd_rdata_out[2:0] == 3'h0)
    else $error("status reserved bits not zero");
  stat_prot_a: assert property (
    rd_stat && $stable(option_shadow_in) |=> cmd_rdata_out[6:5] ==
    {$past(option_shadow_in[OPT_PROT1_BIT]),
     $past(option_shadow_in[OPT_RWP_BIT])})
    else $error("protection mirror wrong");
  stat_mode_a: assert property (
    ce_in && cmd_in.we && cmd_in.code == CMD_WR_CTRL ##5 rd_stat
    |=> cmd_rdata_out[STAT_FLASH_CONTROL_MODE_FLAG_BIT] == $past(cmd_in.wdata[7], 6))
    else $error("mode bit does not follow control write");
  bypass_stall_a: assert property (
    bypass_out |-> !req_ready_out)
    else $error("ready while bypassed");
  busy_ready_a: assert property (
    array_we_out || array_erase_out || array_mass_out |-> !req_ready_out)
    else $error("ready during operation");
  brown_exit_a: assert property (
    brownout_in |=> !port_mode_out && !bypass_out)
    else $error("brownout left port mode on");
  por_exit_a: assert property (
    $fell(por_in) && strap_ok |-> ##[1:2] !port_mode_out)
    else $error("power-on with strap kept port mode");
  test_hold_a: assert property (
    !(cmd_in.we && cmd_in.code == CMD_WR_TEST) && !brownout_in && !por_in
    |=> $stable(bypass_out))
    else $error("bypass changed without test write");

  cover property (cmd_in.we && cmd_in.code == CMD_WR_TEST ##1 bypass_out);
  cover property ($rose(array_erase_out));
  cover property ($fell(por_in) && strap_ok);
endmodule

bind ppfs_top ppfs_top_chk u_chk (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
  .por_in(por_in), .brownout_in(brownout_in), .strap_in(strap_in),
  .cmd_in(cmd_in), .option_shadow_in(option_shadow_in),
  .cmd_rdata_out(cmd_rdata_out), .cmd_rvalid_out(cmd_rvalid_out),
  .port_mode_out(port_mode_out), .bypass_out(bypass_out),
  .req_ready_out(req_ready_out), .array_we_out(array_we_out),
  .array_erase_out(array_erase_out), .array_mass_out(array_mass_out)
);

// >>> sim/ppfs_prog_model.sv
// Model of the external programmer on the serial programming port.
// Assumes decoded commands and requests sampled on the rising edge.
`timescale 1ns/1ns
module ppfs_prog_model
  import ppfs_pkg::*;
(
  input wire logic mclk_in,
  input wire logic [7:0] cmd_rdata_in,
  input wire logic cmd_rvalid_in,
  input wire logic req_ready_in,
  input wire logic req_reject_in,
  output ppfs_cmd_t cmd_out,
  output ppfs_req_t req_out
);
  initial begin
    cmd_out = '0;
    req_out = '0;
  end

  // One command, then idle with the data lines scrambled
  task automatic issue(input logic we, input logic [7:0] code,
      input logic [7:0] wd, output logic [7:0] rd);
    @(posedge mclk_in);
    cmd_out <= '{we: we, re: !we, code: code, wdata: wd};
    @(posedge mclk_in);
    cmd_out <= '{we: 1'b0, re: 1'b0, code: ~code, wdata: ~wd};
    @(posedge mclk_in);
    rd = (cmd_rvalid_in === 1'b1 || we) ? cmd_rdata_in : 8'hXX;
    repeat (2) @(posedge mclk_in);
  endtask

  task automatic rd(input logic [7:0] code, output logic [7:0] d);
    issue(1'b0, code, 8'h00, d);
  endtask

  task automatic wr_test(input logic [7:0] d);
    logic [7:0] x;
    issue(1'b1, CMD_WR_TEST, d | 8'hFB, x);
  endtask

  task automatic wr_ctrl(input logic b);
    logic [7:0] x;
    issue(1'b1, CMD_WR_CTRL, {b, 7'h7F}, x);
  endtask

  task automatic wait_idle(output int polls);
    logic [7:0] s;
    polls = 0;
    do begin
      rd(CMD_RD_STAT, s);
      polls++;
    end while (s[STAT_BUSY_BIT] !== 1'b0 && polls < 1000);
  endtask

  task automatic flash_op(input ppfs_op_t op, input logic info,
      input logic [15:0] a, input logic [7:0] d, output logic rej);
    int n;
    n = 0;
    @(posedge mclk_in);
    req_out <= '{valid: 1'b1, from_port: 1'b1, info: info, op: op,
                 addr: a, data: d};
    do begin
      @(posedge mclk_in);
      n++;
    end while (req_ready_in !== 1'b1 && n < 100);
    req_out <= '{valid: 1'b0, from_port: 1'b1, info: ~info, op: op,
                 addr: ~a, data: ~d};
    @(posedge mclk_in);
    rej = req_reject_in;
  endtask
endmodule

// >>> sim/tb.sv
// Self-checking bench for ppfs_top driven by the programmer model.
// Assumes the checker file binds itself to the design.
`timescale 1ns/1ns
module tb;
  import ppfs_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic por_in = 1'b0;
  logic brownout_in = 1'b0;
  logic strap_in = 1'b1;
  logic [7:0] option_shadow_in = 8'h00;
  logic [7:0] sector_lock_in = 8'h00;
  ppfs_cmd_t cmd;
  ppfs_req_t port_req;
  logic [7:0] cmd_rdata, rdata;
  logic cmd_rvalid, port_mode, bypass, ready, reject, rvalid, we, er, ms;
  logic ce_in = 1'b1;
  logic hi;
  logic [15:0] aout, wout;
  ppfs_req_t cpu_req = '0;
  int fail_count = 0;
  int samples_checked = 0;
  ppfs_op_t ops [4] = '{PPFS_OP_PROG, PPFS_OP_PAGE_ERASE,
                        PPFS_OP_MASS_ERASE, PPFS_OP_PROG};
  logic [15:0] adr [4] = '{16'h0101, 16'h0234, 16'h0000, 16'h00C0};
  logic [15:0] pga [4] = '{16'h0101, 16'h0200, 16'h0000, 16'h00C0};
  int len [4] = '{PROG_CYCLES, ERASE_CYCLES, ERASE_CYCLES, PROG_CYCLES};
  logic [2:0] stb [4] = '{3'h4, 3'h2, 3'h1, 3'h4};
  always #50 mclk_in = ~mclk_in;

  ppfs_top dut (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .por_in(por_in), .brownout_in(brownout_in), .strap_in(strap_in),
    .cmd_in(cmd), .option_shadow_in(option_shadow_in),
    .sector_lock_in(sector_lock_in), .cpu_req_in(cpu_req),
    .port_req_in(port_req), .array_rdata_in(16'h5AC3),
    .cmd_rdata_out(cmd_rdata), .cmd_rvalid_out(cmd_rvalid),
    .port_mode_out(port_mode), .bypass_out(bypass),
    .req_ready_out(ready), .req_reject_out(reject), .rdata_out(rdata),
    .rvalid_out(rvalid), .array_we_out(we), .array_erase_out(er),
    .array_mass_out(ms), .array_hi_out(hi), .array_addr_out(aout),
    .array_wdata_out(wout)
  );

  ppfs_prog_model m (
    .mclk_in(mclk_in), .cmd_rdata_in(cmd_rdata),
    .cmd_rvalid_in(cmd_rvalid), .req_ready_in(ready),
    .req_reject_in(reject), .cmd_out(cmd), .req_out(port_req)
  );

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // CPU byte program, held until the sequencer shows ready
  task automatic cpu_prog(input logic [15:0] a, output logic rj,
      output logic w);
    @(posedge mclk_in);
    cpu_req <= '{valid: 1'b1, from_port: 1'b0, info: 1'b0,
                 op: PPFS_OP_PROG, addr: a, data: 8'h3C};
    do begin
      @(posedge mclk_in);
    end while (ready !== 1'b1);
    cpu_req <= '0;
    @(posedge mclk_in);
    rj = reject;
    w = we;
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge mclk_in);
    fail_count++;
    end_sim();
  end

  initial begin
    logic [7:0] d, x;
    logic rej, w;
    int polls, n;
    time t0;
    repeat (12) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    m.issue(1'b1, CMD_RD_STAT, 8'hFF, x);
    m.rd(CMD_RD_STAT, x);
    check(x, STAT_RESET);
    m.rd(CMD_RD_TEST, x);
    check(x, TEST_RESET);
    for (int i = 0; i < 2; i++) begin
      d = (i == 0) ? 8'h04 : 8'h00;
      m.wr_test(d);
      check(bypass, d[2]);
      check(ready, !d[2]);
      m.rd(CMD_RD_TEST, x);
      check(x, d);
    end
    for (int o = 0; o < 4; o++) begin
      option_shadow_in <= 8'(o);
      m.rd(CMD_RD_STAT, x);
      check(x, 8'(o) << 5);
    end
    for (int c = 0; c < 3; c++) begin
      m.wr_ctrl(c != 1);
      m.rd(CMD_RD_STAT, x);
      check(x[7], c != 1);
    end
    sector_lock_in <= 8'hFF;
    for (int i = 0; i < 4; i++) begin
      m.flash_op(ops[i], i == 3, adr[i], 8'hA5, rej);
      t0 = $time;
      check({rej, we, er, ms}, {1'b0, stb[i]});
      check(aout, pga[i]);
      check(hi, adr[i][0]);
      check(wout, 16'hA5A5);
      m.rd(CMD_RD_STAT, x);
      check(x[STAT_BUSY_BIT], 1'b1);
      m.wait_idle(polls);
      n = int'(($time - t0) / 100);
      check(n >= len[i] && n <= len[i] + 12, 1'b1);
    end
    cpu_prog(16'h2000, rej, w);
    check({rej, w}, 2'b10);
    sector_lock_in <= 8'hFD;
    cpu_prog(16'h2000, rej, w);
    check({rej, w}, 2'b01);
    m.rd(CMD_RD_STAT, x);
    check(x[STAT_BUSY_BIT], 1'b0);
    repeat (PROG_CYCLES) @(posedge mclk_in);
    check(ready, 1'b1);
    m.flash_op(PPFS_OP_PROG, 1'b1, 16'h0000, 8'hA5, rej);
    check(rej, 1'b1);
    for (int r = 0; r < 2; r++) begin
      m.flash_op(PPFS_OP_READ, 1'b0, {15'h0080, r[0]}, 8'h00,
                 rej);
      n = 0;
      while (rvalid !== 1'b1 && n < 4) begin
        @(posedge mclk_in);
        n++;
      end
      check(rvalid, 1'b1);
      check(rdata, r[0] ? 8'h5A : 8'hC3);
    end
    ce_in <= 1'b0;
    m.wr_test(8'h04);
    check(bypass, 1'b0);
    ce_in <= 1'b1;
    m.wr_test(8'h04);
    brownout_in <= 1'b1;
    @(posedge mclk_in);
    brownout_in <= 1'b0;
    @(posedge mclk_in);
    check({port_mode, bypass}, 2'b00);
    for (int s = 0; s < 2; s++) begin
      m.wr_ctrl(1'b1);
      check(port_mode, 1'b1);
      strap_in <= s[0];
      por_in <= 1'b1;
      repeat (5) @(posedge mclk_in);
      por_in <= 1'b0;
      repeat (3) @(posedge mclk_in);
      check(port_mode, !s[0]);
      strap_in <= 1'b1;
    end
    end_sim();
  end
endmodule
